// ---- adcrg_pkg.sv ----
// Constants, field layouts and types for the ADC identity, status and input selection bank.
// Assumes one 50 MHz clock domain and a serial command port sampled in that domain.

package adcrg_pkg;

    // ==========================================================================
    // Register addresses
    // ==========================================================================
    localparam logic [4:0] ADDR_DEVICE_IDENTITY = 5'h00;
    localparam logic [4:0] ADDR_DEVICE_STATUS_FLAGS = 5'h01;
    localparam logic [4:0] ADDR_INPUT_SELECTION = 5'h02;

    // ==========================================================================
    // Reset values
    // ==========================================================================
    localparam logic [7:0] DEVICE_STATUS_FLAGS_RESET = 8'h80;
    localparam logic [7:0] INPUT_SELECTION_RESET = 8'h01;

    // ==========================================================================
    // Field positions
    // ==========================================================================
    localparam int MODEL_CODE_LSB = 0;
    localparam int MODEL_CODE_W = 3;
    localparam int IDENTITY_RSVD_LSB = 3;
    localparam int IDENTITY_RSVD_W = 5;
    localparam int POWER_ON_FLAG_POS = 7;
    localparam int NOT_READY_POS = 6;
    localparam int MONITOR_FLAGS_LSB = 0;
    localparam int MONITOR_FLAGS_W = 6;
    localparam int POS_SELECT_LSB = 4;
    localparam int NEG_SELECT_LSB = 0;
    localparam int SELECT_W = 4;
    localparam int REF_ENABLE_W = 2;

    // ==========================================================================
    // Serial command coding
    // ==========================================================================
    localparam int CMD_OPCODE_LSB = 5;
    localparam int CMD_ADDR_W = 5;
    localparam int CMD_COUNT_W = 5;
    localparam logic [2:0] REGISTER_READ_CMD = 3'h1;
    localparam logic [2:0] REGISTER_WRITE_CMD = 3'h2;
    localparam logic [7:0] IDLE_READ_BYTE = 8'h00;

    // ==========================================================================
    // Types
    // ==========================================================================
    // Bit order matches status bits 5 down to 0.
    typedef struct packed {
        logic pos_out_near_top_rail;
        logic pos_out_near_bottom_rail;
        logic neg_out_near_top_rail;
        logic neg_out_near_bottom_rail;
        logic ref_below_third_supply;
        logic ref_missing;
    } adcrg_monitor_t;

    typedef struct packed {
        logic [SELECT_W-1:0] positive_input_select;
        logic [SELECT_W-1:0] negative_input_select;
    } adcrg_input_sel_t;

    typedef enum logic [1:0] {
        ADCRG_CMD = 2'b00,
        ADCRG_COUNT = 2'b01,
        ADCRG_DATA = 2'b11
    } adcrg_state_t;

endpackage

// ---- adcrg_serial_byte.sv ----
// Byte engine of the serial command port: shifts command and data bytes in and read bytes out.
// Assumes chip select, serial clock and data in are already synchronous to ref_clk, with each
// serial clock level held for at least two ref_clk cycles; serial clock idles low.

`timescale 1ns/10ps
`default_nettype none

module adcrg_serial_byte (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Serial pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    // Byte side
    input wire logic [7:0] tx_byte,
    output logic rx_valid,
    output logic [7:0] rx_byte
);

    // ==========================================================================
    // Edge detection
    // ==========================================================================
    logic sclk_q;
    logic [2:0] bit_count;
    logic [6:0] rx_shift;
    logic [6:0] tx_shift;
    logic sclk_rise;
    logic sclk_fall;

    assign sclk_rise = sclk & ~sclk_q & ~cs_n;
    assign sclk_fall = ~sclk & sclk_q & ~cs_n;
    assign dout_oe = ~cs_n;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk;
        end
    end

    // ==========================================================================
    // Receive: data in is taken on the falling serial clock edge, MSB first
    // ==========================================================================
    always_ff @(posedge ref_clk) begin
        if (rst || cs_n) begin
            bit_count <= 3'h0;
            rx_shift <= 7'h00;
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            rx_valid <= 1'b0;
            if (sclk_fall) begin
                bit_count <= bit_count + 3'h1;
                rx_shift <= {rx_shift[5:0], din};
                if (bit_count == 3'h7) begin
                    rx_valid <= 1'b1;
                    rx_byte <= {rx_shift, din};
                end
            end
        end
    end

    // ==========================================================================
    // Transmit: each bit leaves on the rising edge, the byte is loaded at its first bit
    // ==========================================================================
    always_ff @(posedge ref_clk) begin
        if (rst || cs_n) begin
            tx_shift <= 7'h00;
            dout <= 1'b0;
        end else if (sclk_rise) begin
            if (bit_count == 3'h0) begin
                dout <= tx_byte[7];
                tx_shift <= tx_byte[6:0];
            end else begin
                dout <= tx_shift[6];
                tx_shift <= {tx_shift[5:0], 1'b0};
            end
        end
    end

endmodule

`default_nettype wire

// ---- adcrg_regs.sv ----
// Identity, status and input selection registers of the ADC, reached by serial commands.
// Assumes the analog monitors deliver raw comparator levels and a one-cycle conversion strobe,
// and that the monitor enables live in registers elsewhere and arrive as plain levels.
//
// Summary of operation
// - Read-only identity register sits at address 00h.
// - Low three identity bits give the model code.
// - Identity bits 7:3 reserved; host ignores them.
// - Status register at 01h, resets to 80h.
// - Power-on flag set by power-on reset, sticky.
// - Only a host write clears the power-on flag.
// - Status bit 6 reads 1 until start-up completes.
// - Bit 5: positive output near top rail.
// - Bit 4: positive output near bottom rail.
// - Bit 3: negative output near top rail.
// - Bit 2: negative output near bottom rail.
// - Bit 1: reference below third of supply.
// - Bit 0: reference missing, below threshold.
// - Rail flags work only with rail monitor enabled.
// - Reference flags follow the two-bit reference enable.
// - Input selection at 02h, resets 01h, two nibbles.
// - Registers reached only by serial read/write commands.
// - Selection code maps to same-index input; rest reserved.

`timescale 1ns/10ps
`default_nettype none

module adcrg_regs #(
    // Arbitrary neutral value; a real part straps its own model code here.
    parameter logic [2:0] MODEL_CODE = 3'h7,
    // Arbitrary neutral value for the reserved identity bits.
    parameter logic [4:0] IDENTITY_RESERVED = 5'h00,
    parameter int NUM_INPUTS = 12
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Serial command port
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    // Analog monitors and their enables
    input wire adcrg_pkg::adcrg_monitor_t monitor_raw,
    input wire logic conversion_strobe,
    input wire logic rail_monitor_enable,
    input wire logic [1:0] ref_monitor_enable,
    input wire logic startup_done,
    // Input multiplexer control
    output adcrg_pkg::adcrg_input_sel_t input_sel,
    output logic select_reserved,
    output logic input_selection_written,
    // Status view
    output logic power_on_flag
);

    // ==========================================================================
    // Elaboration checks
    // ==========================================================================
    if (NUM_INPUTS < 1 || NUM_INPUTS > 16) begin : g_bad_num_inputs
        $error("NUM_INPUTS must lie between 1 and 16.");
    end

    // ==========================================================================
    // Helper functions
    // ==========================================================================
    // True when the address belongs to this bank.
    function automatic logic in_bank(input logic [4:0] addr);
        in_bank = (addr == adcrg_pkg::ADDR_DEVICE_IDENTITY) ||
                  (addr == adcrg_pkg::ADDR_DEVICE_STATUS_FLAGS) ||
                  (addr == adcrg_pkg::ADDR_INPUT_SELECTION);
    endfunction

    // True when a selection code names no implemented input.
    function automatic logic code_reserved(input logic [3:0] code);
        code_reserved = ({1'b0, code} >= 5'(NUM_INPUTS));
    endfunction

    // ==========================================================================
    // Byte engine
    // ==========================================================================
    logic rx_valid;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;

    adcrg_serial_byte u_serial_byte (
        .ref_clk(ref_clk),
        .rst(rst),
        .cs_n(cs_n),
        .sclk(sclk),
        .din(din),
        .dout(dout),
        .dout_oe(dout_oe),
        .tx_byte(tx_byte),
        .rx_valid(rx_valid),
        .rx_byte(rx_byte)
    );

    // ==========================================================================
    // Command sequencer
    // ==========================================================================
    adcrg_pkg::adcrg_state_t state;
    logic is_write;
    logic [4:0] cur_addr;
    logic [4:0] bytes_left;
    logic write_strobe;
    logic [4:0] write_addr;
    logic [7:0] write_data;
    logic [7:0] read_value;
    logic [7:0] next_tx_byte;

    // Access is only by the register read and write commands.
    always_ff @(posedge ref_clk) begin
        if (rst || cs_n) begin
            state <= adcrg_pkg::ADCRG_CMD;
            is_write <= 1'b0;
            cur_addr <= 5'h00;
            bytes_left <= 5'h00;
        end else if (rx_valid) begin
            unique case (state)
                adcrg_pkg::ADCRG_CMD: begin
                    cur_addr <= rx_byte[adcrg_pkg::CMD_ADDR_W-1:0];
                    if (rx_byte[7:adcrg_pkg::CMD_OPCODE_LSB] == adcrg_pkg::REGISTER_READ_CMD) begin
                        is_write <= 1'b0;
                        state <= adcrg_pkg::ADCRG_COUNT;
                    end else if (rx_byte[7:adcrg_pkg::CMD_OPCODE_LSB] == adcrg_pkg::REGISTER_WRITE_CMD) begin
                        is_write <= 1'b1;
                        state <= adcrg_pkg::ADCRG_COUNT;
                    end
                end
                adcrg_pkg::ADCRG_COUNT: begin
                    bytes_left <= rx_byte[adcrg_pkg::CMD_COUNT_W-1:0];
                    state <= adcrg_pkg::ADCRG_DATA;
                end
                adcrg_pkg::ADCRG_DATA: begin
                    cur_addr <= cur_addr + 5'h01;
                    bytes_left <= bytes_left - 5'h01;
                    if (bytes_left == 5'h00) begin
                        state <= adcrg_pkg::ADCRG_CMD;
                    end
                end
            endcase
        end
    end

    // A completed data byte of a write command lands at the current address.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            write_strobe <= 1'b0;
            write_addr <= 5'h00;
            write_data <= 8'h00;
        end else begin
            write_strobe <= rx_valid && !cs_n && is_write && (state == adcrg_pkg::ADCRG_DATA) && in_bank(cur_addr);
            write_addr <= cur_addr;
            write_data <= rx_byte;
        end
    end

    // ==========================================================================
    // Read byte preparation
    // ==========================================================================
    // The byte for the next read slot is prepared as soon as the previous byte completes.
    always_comb begin
        next_tx_byte = tx_byte;
        if (cs_n) begin
            next_tx_byte = adcrg_pkg::IDLE_READ_BYTE;
        end else if (rx_valid) begin
            next_tx_byte = adcrg_pkg::IDLE_READ_BYTE;
            if (!is_write && state == adcrg_pkg::ADCRG_COUNT) begin
                next_tx_byte = read_value;
            end else if (!is_write && state == adcrg_pkg::ADCRG_DATA && bytes_left != 5'h00) begin
                next_tx_byte = read_mux(cur_addr + 5'h01);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_byte <= adcrg_pkg::IDLE_READ_BYTE;
        end else begin
            tx_byte <= next_tx_byte;
        end
    end

    assign read_value = read_mux(cur_addr);

    // ==========================================================================
    // Identity register
    // ==========================================================================
    logic [7:0] device_identity;

    // Fixed model code and reserved bits, never writable.
    assign device_identity = {IDENTITY_RESERVED, MODEL_CODE};

    // ==========================================================================
    // Status register
    // ==========================================================================
    logic not_ready;
    adcrg_pkg::adcrg_monitor_t monitor_meta;
    adcrg_pkg::adcrg_monitor_t monitor_sync;
    adcrg_pkg::adcrg_monitor_t monitor_flags;
    logic [7:0] device_status_flags;

    // Reset is the power-on event; only a host write of 0 clears the flag.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            power_on_flag <= adcrg_pkg::DEVICE_STATUS_FLAGS_RESET[adcrg_pkg::POWER_ON_FLAG_POS];
        end else if (write_strobe && write_addr == adcrg_pkg::ADDR_DEVICE_STATUS_FLAGS) begin
            power_on_flag <= power_on_flag & write_data[adcrg_pkg::POWER_ON_FLAG_POS];
        end
    end

    // Start-up indicator reads 1 until the converter reports start-up done.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            not_ready <= adcrg_pkg::DEVICE_STATUS_FLAGS_RESET[adcrg_pkg::NOT_READY_POS];
        end else begin
            not_ready <= ~startup_done;
        end
    end

    // Comparator levels come from the analog side and are synchronised first.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            monitor_meta <= '0;
            monitor_sync <= '0;
        end else begin
            monitor_meta <= monitor_raw;
            monitor_sync <= monitor_meta;
        end
    end

    // Rail flags exist only while the rail monitor is enabled.
    always_ff @(posedge ref_clk) begin
        if (rst || !rail_monitor_enable) begin
            monitor_flags.pos_out_near_top_rail <= 1'b0;
            monitor_flags.pos_out_near_bottom_rail <= 1'b0;
            monitor_flags.neg_out_near_top_rail <= 1'b0;
            monitor_flags.neg_out_near_bottom_rail <= 1'b0;
        end else if (conversion_strobe) begin
            monitor_flags.pos_out_near_top_rail <= monitor_sync.pos_out_near_top_rail;
            monitor_flags.pos_out_near_bottom_rail <= monitor_sync.pos_out_near_bottom_rail;
            monitor_flags.neg_out_near_top_rail <= monitor_sync.neg_out_near_top_rail;
            monitor_flags.neg_out_near_bottom_rail <= monitor_sync.neg_out_near_bottom_rail;
        end
    end

    // Any nonzero reference enable arms the missing check; the upper bit arms the third check.
    always_ff @(posedge ref_clk) begin
        if (rst || !ref_monitor_enable[1]) begin
            monitor_flags.ref_below_third_supply <= 1'b0;
        end else if (conversion_strobe) begin
            monitor_flags.ref_below_third_supply <= monitor_sync.ref_below_third_supply;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || ref_monitor_enable == 2'h0) begin
            monitor_flags.ref_missing <= 1'b0;
        end else if (conversion_strobe) begin
            monitor_flags.ref_missing <= monitor_sync.ref_missing;
        end
    end

    // Assembled status byte, resetting to 80h.
    assign device_status_flags = {power_on_flag, not_ready, monitor_flags};

    // ==========================================================================
    // Input selection register
    // ==========================================================================
    // Both nibbles reset to their documented codes and are written whole.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            input_sel <= adcrg_pkg::INPUT_SELECTION_RESET;
            input_selection_written <= 1'b0;
        end else begin
            input_selection_written <= 1'b0;
            if (write_strobe && write_addr == adcrg_pkg::ADDR_INPUT_SELECTION) begin
                input_sel <= write_data;
                input_selection_written <= 1'b1;
            end
        end
    end

    // Codes beyond the last implemented input are flagged as reserved.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            select_reserved <= 1'b0;
        end else begin
            select_reserved <= code_reserved(input_sel.positive_input_select) |
                               code_reserved(input_sel.negative_input_select);
        end
    end

    // ==========================================================================
    // Register read multiplexer
    // ==========================================================================
    function automatic logic [7:0] read_mux(input logic [4:0] addr);
        read_mux = adcrg_pkg::IDLE_READ_BYTE;
        if (addr == adcrg_pkg::ADDR_DEVICE_IDENTITY) begin
            read_mux = device_identity;
        end else if (addr == adcrg_pkg::ADDR_DEVICE_STATUS_FLAGS) begin
            read_mux = device_status_flags;
        end else if (addr == adcrg_pkg::ADDR_INPUT_SELECTION) begin
            read_mux = input_sel;
        end
    endfunction

endmodule

`default_nettype wire

// ---- adcrg_assertions.sv ----
// Checker for the identity, status and input selection bank, bound to adcrg_regs.
// Assumes one ref_clk domain and the synchronous active-high rst of the top module.

`timescale 1ns/10ps
`default_nettype none

module adcrg_assertions #(
    parameter int NUM_INPUTS = 12
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Serial pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic dout,
    input wire logic dout_oe,
    // Register outputs
    input wire adcrg_pkg::adcrg_input_sel_t input_sel,
    input wire logic select_reserved,
    input wire logic input_selection_written,
    input wire logic power_on_flag
);
    // ==========================================================================
    // Properties
    // ==========================================================================
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_idle;
        cs_n [*3];
    endsequence
    sequence s_in_frame;
        !cs_n ##1 !cs_n;
    endsequence

    property p_oe;
        dout_oe == !cs_n;
    endproperty
    property p_reset_vals;
        $fell(rst) |-> (input_sel == adcrg_pkg::INPUT_SELECTION_RESET) && power_on_flag;
    endproperty
    property p_por_rise;
        !$rose(power_on_flag);
    endproperty
    property p_por_clear;
        $fell(power_on_flag) |-> !cs_n || $past(!cs_n);
    endproperty
    property p_pulse;
        input_selection_written |=> !input_selection_written;
    endproperty
    property p_pulse_frame;
        input_selection_written |-> $past(!cs_n, 2);
    endproperty
    property p_sel_idle;
        s_idle |-> $stable(input_sel);
    endproperty
    property p_sel_written;
        !$stable(input_sel) |-> input_selection_written || $past(input_selection_written);
    endproperty
    property p_reserved;
        1 |=> select_reserved == (($past(input_sel.positive_input_select) >= NUM_INPUTS) ||
            ($past(input_sel.negative_input_select) >= NUM_INPUTS));
    endproperty
    property p_dout;
        s_in_frame ##0 !$stable(dout) |-> $past(sclk);
    endproperty

    a_oe: assert property (p_oe) else $error("dout_oe differs from chip select");
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
    a_por_rise: assert property (p_por_rise) else $error("power-on flag set without reset");
    a_por_clear: assert property (p_por_clear) else $error("power-on flag cleared outside a frame");
    a_pulse: assert property (p_pulse) else $error("write pulse longer than a cycle");
    a_pulse_frame: assert property (p_pulse_frame) else $error("write pulse outside a frame");
    a_sel_idle: assert property (p_sel_idle) else $error("selection changed while idle");
    a_sel_written: assert property (p_sel_written) else $error("selection changed without write");
    a_reserved: assert property (p_reserved) else $error("reserved code flag wrong");
    a_dout: assert property (p_dout) else $error("dout moved without serial clock");
endmodule

bind adcrg_regs adcrg_assertions #(.NUM_INPUTS(NUM_INPUTS)) i_chk (.ref_clk(ref_clk), .rst(rst),
    .cs_n(cs_n), .sclk(sclk), .dout(dout), .dout_oe(dout_oe), .input_sel(input_sel),
    .select_reserved(select_reserved), .input_selection_written(input_selection_written),
    .power_on_flag(power_on_flag));

`default_nettype wire

// ---- adcrg_host.sv ----
// Host controller model that runs command frames on the serial port.
// Assumes the bank samples din on sclk fall and updates dout after sclk rise.

`timescale 1ns/10ps
`default_nettype none

module adcrg_host (
    // Clock
    input wire logic ref_clk,
    // Serial pins
    output logic cs_n,
    output logic sclk,
    output logic din,
    input wire logic dout,
    input wire logic dout_oe
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end

    // ==========================================================================
    // Three-byte frame: command, count, data
    // ==========================================================================
    // Only register read and write commands are sent; identity bits 7:3 are left to the caller.
    task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
        output logic [7:0] r);
        logic [23:0] tx;
        tx = {b0, b1, b2};
        r = 8'h00;
        @(posedge ref_clk);
        cs_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        for (int i = 23; i >= 0; i--) begin
            sclk <= 1'b1;
            din <= tx[i];
            repeat (4) @(posedge ref_clk);
            r = {r[6:0], dout & dout_oe};
            sclk <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
        cs_n <= 1'b1;
        // A released line must not keep showing the last bit.
        din <= ~tx[0];
        @(posedge ref_clk);
    endtask
endmodule

`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for adcrg_regs with a host model on the serial port.
// Assumes the bind in the checker file attaches the assertions.

`timescale 1ns/10ps
`default_nettype none

module testbench;
    localparam int NUM_IN = 12;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic cs_n, sclk, din, dout, dout_oe;
    adcrg_pkg::adcrg_monitor_t raw = '0;
    logic strobe = 1'b0;
    logic rail_en = 1'b0;
    logic [1:0] ref_en = 2'h0;
    logic startup_done = 1'b0;
    adcrg_pkg::adcrg_input_sel_t input_sel;
    logic select_reserved, written, por;
    logic [31:0] seed = 32'h1db3898c;
    int n_errors = 0;
    int comparisons = 0;
    int n_written = 0;
    always @(posedge ref_clk) n_written <= n_written + int'(written);

    // Arbitrary model code, not one of any real part.
    adcrg_regs #(.MODEL_CODE(3'h6), .IDENTITY_RESERVED(5'h00), .NUM_INPUTS(NUM_IN)) i_adcrg_regs (
        .ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
        .dout_oe(dout_oe), .monitor_raw(raw), .conversion_strobe(strobe), .rail_monitor_enable(rail_en),
        .ref_monitor_enable(ref_en), .startup_done(startup_done), .input_sel(input_sel),
        .select_reserved(select_reserved), .input_selection_written(written), .power_on_flag(por));
    adcrg_host i_adcrg_host (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
        .dout_oe(dout_oe));

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    // ==========================================================================
    // Helpers
    // ==========================================================================
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    function automatic logic [7:0] exp_status(logic p, logic nr, logic [5:0] m, logic re, logic [1:0] fe);
        return {p, nr, m[5:2] & {4{re}}, m[1] & fe[1], m[0] & (fe != 2'h0)};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] r);
        i_adcrg_host.frame({adcrg_pkg::REGISTER_READ_CMD, a}, 8'h00, 8'h00, r);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] r;
        i_adcrg_host.frame({adcrg_pkg::REGISTER_WRITE_CMD, a}, 8'h00, d, r);
    endtask
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        n_errors++;
        final_report;
    end

    // ==========================================================================
    // Scenarios
    // ==========================================================================
    initial begin
        logic [7:0] r;
        logic [7:0] d;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        check(input_sel, 8'h01);
        check({7'h0, por}, 8'h01);
        rd(adcrg_pkg::ADDR_DEVICE_IDENTITY, r);
        check({5'h0, r[2:0]}, 8'h06);
        wr(adcrg_pkg::ADDR_DEVICE_IDENTITY, 8'h01);
        rd(adcrg_pkg::ADDR_DEVICE_IDENTITY, r);
        check({5'h0, r[2:0]}, 8'h06);
        rd(adcrg_pkg::ADDR_DEVICE_STATUS_FLAGS, r);
        check(r, 8'hc0);
        startup_done <= 1'b1;
        rd(adcrg_pkg::ADDR_DEVICE_STATUS_FLAGS, r);
        check(r, 8'h80);
        wr(adcrg_pkg::ADDR_DEVICE_STATUS_FLAGS, 8'hff);
        rd(adcrg_pkg::ADDR_DEVICE_STATUS_FLAGS, r);
        check(r, 8'h80);
        wr(adcrg_pkg::ADDR_DEVICE_STATUS_FLAGS, 8'h7f);
        rd(adcrg_pkg::ADDR_DEVICE_STATUS_FLAGS, r);
        check(r, 8'h00);
        check({7'h0, por}, 8'h00);
        rd(adcrg_pkg::ADDR_INPUT_SELECTION, r);
        check(r, 8'h01);
        wr(5'h03, 8'h5a);
        rd(5'h03, r);
        check(r, 8'h00);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            d = (i == 0) ? 8'hbb : (i == 1) ? 8'hc0 : (i == 2) ? 8'h0c : seed[7:0];
            wr(adcrg_pkg::ADDR_INPUT_SELECTION, d);
            check(input_sel, d);
            @(posedge ref_clk);
            check({7'h0, select_reserved}, {7'h0, (d[7:4] >= NUM_IN) || (d[3:0] >= NUM_IN)});
            rd(adcrg_pkg::ADDR_INPUT_SELECTION, r);
            check(r, d);
        end
        check(8'(n_written), 8'h08);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            raw <= (i == 0) ? 6'h3f : seed[5:0];
            rail_en <= (i == 0) ? 1'b1 : seed[8];
            ref_en <= 2'(i);
            repeat (4) @(posedge ref_clk);
            strobe <= 1'b1;
            @(posedge ref_clk);
            strobe <= 1'b0;
            repeat (3) @(posedge ref_clk);
            d = exp_status(1'b0, 1'b0, raw, rail_en, ref_en);
            rd(adcrg_pkg::ADDR_DEVICE_STATUS_FLAGS, r);
            check(r, d);
        end
        rst <= 1'b1;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        check({7'h0, por}, 8'h01);
        check(input_sel, 8'h01);
        final_report;
    end
endmodule

`default_nettype wire
